// ---- csc_clock_switch.sv ----
// Clock switchover control register and clock gating logic
//
// Overview of operation
// - Bit7 picks metering clock source, reads actual.
// - Bit0 picks CPU clock source, reads actual.
// - Quick-enable writes ignored while fallback set.
// - Quick-enable starts 3.2768 MHz PLL for CPU.
// - Quick-enable locks clocks; clearing keeps source.
// - Fallback selects oscillator, stops PLL, CPU clock.
// - Fallback without power-good enters Sleep only.
// - Fallback with power-good never forces Sleep.
// - Metering gate bit stops metering clock.
// - Display gate works only when both on PLL.
// - Sleep codes 11/01 enter Sleep from oscillator without power-good.
// - Sleep code 10 enters Deep Sleep without power-good.
// - Wakeup resumes execution without any reset.
// - Wakeup clears only sleep and quick bits.
// - Reset and wakeup clear quick bits.
// - PLL-to-oscillator switch takes one oscillator cycle.
// - Lost PLL falls to 32768 Hz, select stays.
// - Quick mode blocks CPU select, holds 3.2768 MHz.
`timescale 1ns/10ps
module csc_clock_switch (
   input  wire logic       core_clk,
   input  wire logic       srst,
   input  wire logic [7:0] sfr_addr,
   input  wire logic       sfr_wr,
   input  wire logic       sfr_rd,
   input  wire logic [7:0] sfr_wdata,
   output logic      [7:0] sfr_rdata,
   input  wire logic       power_good_status,
   input  wire logic       wakeup_event,
   input  wire logic       pll_running,
   output logic            cpu_clock_run,
   output logic            auxiliary_clock_run,
   output logic            cpu_clock_pll,
   output logic            metering_clock_pll,
   output logic            metering_clock_run,
   output logic            display_clock_run,
   output logic            pll_quick_on,
   output logic            pll_force_off,
   output logic            pll_slow_fallback,
   output logic            analog_write_block,
   output logic            sleep_active,
   output logic            deep_sleep_active
);

   localparam logic [csc_pkg::SWITCH_CNT_W-1:0] SWITCH_LOAD =
      csc_pkg::SWITCH_CNT_W'(csc_pkg::SWITCH_CYCLES);

   initial
   begin
      if (csc_pkg::SWITCH_CYCLES < 1 || csc_pkg::SWITCH_CYCLES >= (1 << csc_pkg::SWITCH_CNT_W))
      begin
         $error("csc_clock_switch: switch count does not fit its counter");
      end
   end

   logic [2:0] sync_q;
   logic       pg_s;
   logic       wake_s;
   logic       pll_ok_s;

   csc_sync #(
      .WIDTH (3)
   ) u_sync (
      .core_clk (core_clk),
      .srst     (srst),
      .async_in ({power_good_status, wakeup_event, pll_running}),
      .sync_out (sync_q)
   );

   assign pg_s     = sync_q[2];
   assign wake_s   = sync_q[1];
   assign pll_ok_s = sync_q[0];

   logic                             meter_src;
   logic                             cpu_src;
   logic                             quick_en;
   logic                             quick_fb;
   logic                             meter_gate;
   logic                             disp_gate;
   logic                             sleep_hi;
   logic                             sleep_lo;
   logic                             wake_prev;
   logic [csc_pkg::SWITCH_CNT_W-1:0] meter_cnt;
   logic [csc_pkg::SWITCH_CNT_W-1:0] cpu_cnt;
   csc_pkg::csc_pwr_t                pwr;
   logic [csc_pkg::SWITCH_CNT_W-1:0] block_age;
   logic [csc_pkg::SWITCH_CNT_W-1:0] next_block_age;

   logic                             next_meter_src;
   logic                             next_cpu_src;
   logic                             next_quick_en;
   logic                             next_quick_fb;
   logic                             next_meter_gate;
   logic                             next_disp_gate;
   logic                             next_sleep_hi;
   logic                             next_sleep_lo;
   logic [csc_pkg::SWITCH_CNT_W-1:0] next_meter_cnt;
   logic [csc_pkg::SWITCH_CNT_W-1:0] next_cpu_cnt;
   csc_pkg::csc_pwr_t                next_pwr;
   logic [7:0]                       next_rdata;
   logic                             next_locked;
   logic                             next_cpu_eff;

   logic                             wr_hit;
   logic                             locked;
   logic                             cpu_eff;
   logic                             wake_rise;

   // Quick enable in force only while fallback is clear
   function automatic logic quick_lock(input logic en, input logic fb);
      return en & ~fb;
   endfunction

   assign wr_hit    = sfr_wr && (sfr_addr == csc_pkg::SFR_ADDR_CTRL);
   assign locked    = quick_lock(quick_en, quick_fb);
   assign cpu_eff   = cpu_src | locked;
   assign wake_rise = wake_s & ~wake_prev;

   always_comb
   begin
      next_meter_src  = meter_src;
      next_cpu_src    = cpu_src;
      next_quick_en   = quick_en;
      next_quick_fb   = quick_fb;
      next_meter_gate = meter_gate;
      next_disp_gate  = disp_gate;
      next_sleep_hi   = sleep_hi;
      next_sleep_lo   = sleep_lo;
      next_meter_cnt  = meter_cnt;
      next_cpu_cnt    = cpu_cnt;
      next_pwr        = pwr;

      if (meter_cnt != '0)
      begin
         next_meter_cnt = meter_cnt - 1'b1;
         if (meter_cnt == 1)
         begin
            next_meter_src = 1'b0;
         end
      end
      if (cpu_cnt != '0)
      begin
         next_cpu_cnt = cpu_cnt - 1'b1;
         if (cpu_cnt == 1)
         begin
            next_cpu_src = 1'b0;
         end
      end

      if (wake_rise)
      begin
         next_sleep_hi = 1'b0;
         next_sleep_lo = 1'b0;
         next_quick_en = 1'b0;
         next_quick_fb = 1'b0;
         next_pwr      = csc_pkg::PWR_RUN;
      end

      if (wr_hit)
      begin
         if (!locked)
         begin
            if (sfr_wdata[csc_pkg::BIT_METER_SEL])
            begin
               next_meter_src = 1'b1;
               next_meter_cnt = '0;
            end
            else if (meter_src && meter_cnt == '0)
            begin
               next_meter_cnt = SWITCH_LOAD;
            end
         end
         if (!locked && !quick_fb)
         begin
            if (sfr_wdata[csc_pkg::BIT_CPU_SEL])
            begin
               next_cpu_src = 1'b1;
               next_cpu_cnt = '0;
            end
            else if (cpu_src && cpu_cnt == '0)
            begin
               next_cpu_cnt = SWITCH_LOAD;
            end
         end
         if (!quick_fb)
         begin
            next_quick_en = sfr_wdata[csc_pkg::BIT_QUICK_EN];
            if (quick_en && !sfr_wdata[csc_pkg::BIT_QUICK_EN])
            begin
               next_cpu_src = 1'b1;
               next_cpu_cnt = '0;
            end
         end
         next_quick_fb = sfr_wdata[csc_pkg::BIT_QUICK_FB];
         if (sfr_wdata[csc_pkg::BIT_QUICK_FB] && !quick_fb)
         begin
            next_cpu_src = 1'b0;
            next_cpu_cnt = '0;
            if (!pg_s)
            begin
               next_pwr = csc_pkg::PWR_SLEEP;
            end
         end
         next_meter_gate = sfr_wdata[csc_pkg::BIT_METER_GT];
         next_disp_gate  = sfr_wdata[csc_pkg::BIT_DISP_GT];
         next_sleep_hi   = sfr_wdata[csc_pkg::BIT_SLEEP_HI];
         next_sleep_lo   = sfr_wdata[csc_pkg::BIT_SLEEP_LO];
         if (sfr_wdata[csc_pkg::BIT_SLEEP_HI:csc_pkg::BIT_SLEEP_LO] != csc_pkg::SLEEP_CODE_NONE
             && !pg_s && !cpu_eff && cpu_cnt == '0 && !sfr_wdata[csc_pkg::BIT_QUICK_FB])
         begin
            if (sfr_wdata[csc_pkg::BIT_SLEEP_HI:csc_pkg::BIT_SLEEP_LO]
                == csc_pkg::SLEEP_CODE_DEEP)
            begin
               next_pwr = csc_pkg::PWR_DEEP;
            end
            else
            begin
               next_pwr = csc_pkg::PWR_SLEEP;
            end
         end
      end

      next_locked  = quick_lock(next_quick_en, next_quick_fb);
      next_cpu_eff = next_cpu_src | next_locked;

      next_rdata = 8'h00;
      if (sfr_rd && sfr_addr == csc_pkg::SFR_ADDR_CTRL)
      begin
         next_rdata = {meter_src, quick_en, quick_fb, meter_gate,
                       disp_gate, sleep_hi, sleep_lo, cpu_eff};
      end
   end

   always_ff @(posedge core_clk)
   begin
      if (srst)
      begin
         meter_src           <= csc_pkg::CTRL_RESET[csc_pkg::BIT_METER_SEL];
         quick_en            <= csc_pkg::CTRL_RESET[csc_pkg::BIT_QUICK_EN];
         quick_fb            <= csc_pkg::CTRL_RESET[csc_pkg::BIT_QUICK_FB];
         meter_gate          <= csc_pkg::CTRL_RESET[csc_pkg::BIT_METER_GT];
         disp_gate           <= csc_pkg::CTRL_RESET[csc_pkg::BIT_DISP_GT];
         sleep_hi            <= csc_pkg::CTRL_RESET[csc_pkg::BIT_SLEEP_HI];
         sleep_lo            <= csc_pkg::CTRL_RESET[csc_pkg::BIT_SLEEP_LO];
         cpu_src             <= csc_pkg::CTRL_RESET[csc_pkg::BIT_CPU_SEL];
         meter_cnt           <= '0;
         cpu_cnt             <= '0;
         pwr                 <= csc_pkg::PWR_RUN;
         wake_prev           <= 1'b0;
         sfr_rdata           <= 8'h00;
         cpu_clock_run       <= 1'b1;
         auxiliary_clock_run <= 1'b1;
         cpu_clock_pll       <= 1'b0;
         metering_clock_pll  <= 1'b0;
         metering_clock_run  <= 1'b1;
         display_clock_run   <= 1'b1;
         pll_quick_on        <= 1'b0;
         pll_force_off       <= 1'b0;
         pll_slow_fallback   <= 1'b0;
         analog_write_block  <= 1'b0;
         sleep_active        <= 1'b0;
         deep_sleep_active   <= 1'b0;
      end
      else
      begin
         meter_src           <= next_meter_src;
         quick_en            <= next_quick_en;
         quick_fb            <= next_quick_fb;
         meter_gate          <= next_meter_gate;
         disp_gate           <= next_disp_gate;
         sleep_hi            <= next_sleep_hi;
         sleep_lo            <= next_sleep_lo;
         cpu_src             <= next_cpu_src;
         meter_cnt           <= next_meter_cnt;
         cpu_cnt             <= next_cpu_cnt;
         pwr                 <= next_pwr;
         wake_prev           <= wake_s;
         sfr_rdata           <= next_rdata;
         cpu_clock_run       <= (next_pwr == csc_pkg::PWR_RUN) && !next_quick_fb;
         auxiliary_clock_run <= (next_pwr == csc_pkg::PWR_RUN) && !next_quick_fb;
         cpu_clock_pll       <= next_cpu_eff;
         metering_clock_pll  <= next_meter_src;
         metering_clock_run  <= !next_meter_gate;
         display_clock_run   <= !(next_disp_gate && next_cpu_eff && next_meter_src);
         // quick PLL held at 3.2768 MHz
         pll_quick_on        <= next_locked;
         pll_force_off       <= next_quick_fb;
         // lost PLL drops to 32768 Hz
         pll_slow_fallback   <= !pll_ok_s && !next_quick_fb && (next_cpu_eff || next_meter_src);
         analog_write_block  <= (next_meter_cnt != '0) || (next_cpu_cnt != '0);
         sleep_active        <= next_pwr == csc_pkg::PWR_SLEEP;
         deep_sleep_active   <= next_pwr == csc_pkg::PWR_DEEP;
      end
   end

   // Cycles the analog write block has stood, saturating, for the switch-time check
   always_comb
   begin
      next_block_age = '0;
      if (analog_write_block && block_age != '1)
      begin
         next_block_age = block_age + 1'b1;
      end
      else if (analog_write_block)
      begin
         next_block_age = block_age;
      end
   end

   always_ff @(posedge core_clk)
   begin
      if (srst)
      begin
         block_age <= '0;
      end
      else
      begin
         block_age <= next_block_age;
      end
   end

   sequence s_fb_write;
      wr_hit && sfr_wdata[csc_pkg::BIT_QUICK_FB] && !quick_fb;
   endsequence

   sequence s_deep_write;
      wr_hit && !pg_s && !cpu_eff && cpu_cnt == '0 && !wake_rise
      && sfr_wdata[2:0] == 3'h4 && !sfr_wdata[csc_pkg::BIT_QUICK_FB];
   endsequence

   chk_meter_sel_set: assert property (@(posedge core_clk) disable iff (srst)
      wr_hit && !locked && sfr_wdata[7] |=> metering_clock_pll)
      else $error("metering select write did not take effect");

   chk_quick_en_block: assert property (@(posedge core_clk) disable iff (srst)
      wr_hit && quick_fb && !wake_rise |=> quick_en == $past(quick_en))
      else $error("quick enable changed while fallback set");

   // quick enable gives PLL CPU clock
   chk_quick_pll_cpu: assert property (@(posedge core_clk) disable iff (srst)
      wr_hit && !quick_fb && sfr_wdata[6:5] == 2'h2 && !wake_rise
      |=> cpu_clock_pll && pll_quick_on)
      else $error("quick enable did not select PLL");

   chk_release_keeps: assert property (@(posedge core_clk) disable iff (srst)
      wr_hit && locked && sfr_wdata[6:5] == 2'h0 && !wake_rise
      |=> cpu_clock_pll && !pll_quick_on)
      else $error("quick enable release switched the CPU clock");

   chk_fallback_stop: assert property (@(posedge core_clk) disable iff (srst)
      s_fb_write and !wake_rise |=> !cpu_clock_run && !cpu_clock_pll && pll_force_off)
      else $error("fallback did not stop CPU clock");

   chk_fallback_sleep: assert property (@(posedge core_clk) disable iff (srst)
      s_fb_write and !pg_s and !wake_rise |=> sleep_active && !deep_sleep_active)
      else $error("fallback did not enter Sleep");

   chk_pg_no_sleep: assert property (@(posedge core_clk) disable iff (srst)
      s_fb_write and pg_s and !sleep_active and !deep_sleep_active |=> !sleep_active)
      else $error("fallback forced Sleep with power good");

   chk_disp_gate: assert property (@(posedge core_clk) disable iff (srst)
      !display_clock_run |-> cpu_clock_pll && metering_clock_pll)
      else $error("display clock stopped without both on PLL");

   chk_deep_sleep: assert property (@(posedge core_clk) disable iff (srst)
      s_deep_write |=> deep_sleep_active && !cpu_clock_run && !auxiliary_clock_run)
      else $error("sleep code 10 did not enter Deep Sleep");

   // wakeup clears sleep and quick bits
   chk_wake_clear: assert property (@(posedge core_clk) disable iff (srst)
      wake_rise && !wr_hit |=> !quick_en && !quick_fb && !sleep_hi && !sleep_lo
      && metering_clock_run == $past(metering_clock_run) && cpu_clock_run)
      else $error("wakeup did not restore state properly");

   // switch back within one oscillator cycle
   chk_switch_time: assert property (@(posedge core_clk) disable iff (srst)
      analog_write_block |-> block_age < SWITCH_LOAD)
      else $error("clock switch took longer than one oscillator cycle");

endmodule // csc_clock_switch

// ---- csc_pkg.sv ----
// Constants and types for the clock switchover control block
package csc_pkg;

   localparam logic [7:0] SFR_ADDR_CTRL = 8'h80;
   localparam logic [7:0] CTRL_RESET    = 8'h00;

   localparam int BIT_METER_SEL = 7;
   localparam int BIT_QUICK_EN  = 6;
   localparam int BIT_QUICK_FB  = 5;
   localparam int BIT_METER_GT  = 4;
   localparam int BIT_DISP_GT   = 3;
   localparam int BIT_SLEEP_HI  = 2;
   localparam int BIT_SLEEP_LO  = 1;
   localparam int BIT_CPU_SEL   = 0;

   localparam logic [1:0] SLEEP_CODE_DEEP = 2'h2;
   localparam logic [1:0] SLEEP_CODE_NONE = 2'h0;

   localparam int CORE_PERIOD_NS = 8;
   localparam int OSC_FREQ_HZ    = 32768;
   // One oscillator period, longest time, so rounded down
   localparam int SWITCH_CYCLES  = 1000000000 / (OSC_FREQ_HZ * CORE_PERIOD_NS);
   localparam int SWITCH_CNT_W   = 12;

   typedef enum logic [2:0] {
      PWR_RUN   = 3'b001,
      PWR_SLEEP = 3'b010,
      PWR_DEEP  = 3'b100
   } csc_pwr_t;

endpackage

// ---- csc_sync.sv ----
// Two flip-flop synchroniser for asynchronous levels
`timescale 1ns/10ps
module csc_sync #(
   parameter int WIDTH = 1
) (
   input  wire logic             core_clk,
   input  wire logic             srst,
   input  wire logic [WIDTH-1:0] async_in,
   output logic      [WIDTH-1:0] sync_out
);

   logic [WIDTH-1:0] stage1;

   initial
   begin
      if (WIDTH < 1)
      begin
         $error("csc_sync: WIDTH must be at least 1");
      end
   end

   always_ff @(posedge core_clk)
   begin
      if (srst)
      begin
         stage1   <= '0;
         sync_out <= '0;
      end
      else
      begin
         stage1   <= async_in;
         sync_out <= stage1;
      end
   end

endmodule // csc_sync

// ---- tb_top.sv ----
// Self-checking testbench for the clock switchover control block
`timescale 1ns/10ps
module tb_top;
   logic       core_clk          = 1'b0;
   logic       srst              = 1'b1;
   logic [7:0] sfr_addr          = 8'h00;
   logic       sfr_wr            = 1'b0;
   logic       sfr_rd            = 1'b0;
   logic [7:0] sfr_wdata         = 8'h00;
   logic [7:0] sfr_rdata;
   logic       power_good_status = 1'b1;
   logic       wakeup_event      = 1'b0;
   logic       pll_running       = 1'b1;
   logic       cpu_clock_run;
   logic       auxiliary_clock_run;
   logic       cpu_clock_pll;
   logic       metering_clock_pll;
   logic       metering_clock_run;
   logic       display_clock_run;
   logic       pll_quick_on;
   logic       pll_force_off;
   logic       pll_slow_fallback;
   logic       analog_write_block;
   logic       sleep_active;
   logic       deep_sleep_active;
   int         err_count         = 0;
   int         compares          = 0;
   int         n_sw;

   always #4 core_clk = ~core_clk;

   csc_clock_switch dut_u (
      .core_clk            (core_clk),
      .srst                (srst),
      .sfr_addr            (sfr_addr),
      .sfr_wr              (sfr_wr),
      .sfr_rd              (sfr_rd),
      .sfr_wdata           (sfr_wdata),
      .sfr_rdata           (sfr_rdata),
      .power_good_status   (power_good_status),
      .wakeup_event        (wakeup_event),
      .pll_running         (pll_running),
      .cpu_clock_run       (cpu_clock_run),
      .auxiliary_clock_run (auxiliary_clock_run),
      .cpu_clock_pll       (cpu_clock_pll),
      .metering_clock_pll  (metering_clock_pll),
      .metering_clock_run  (metering_clock_run),
      .display_clock_run   (display_clock_run),
      .pll_quick_on        (pll_quick_on),
      .pll_force_off       (pll_force_off),
      .pll_slow_fallback   (pll_slow_fallback),
      .analog_write_block  (analog_write_block),
      .sleep_active        (sleep_active),
      .deep_sleep_active   (deep_sleep_active)
   );

   // Prints the counts and the verdict, then ends the run
   task automatic final_report();
      $display("Comparisons %0d, mismatches %0d", compares, err_count);
      if (err_count == 0 && compares > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string msg);
      compares++;
      if (got !== exp)
      begin
         err_count++;
         $display("CHECK FAILED at %0t: %s got %h expected %h", $time, msg, got, exp);
      end
   endtask

   task automatic chk1(input logic got, input logic exp, input string msg);
      compares++;
      if (got !== exp)
      begin
         err_count++;
         $display("CHECK FAILED at %0t: %s got %b expected %b", $time, msg, got, exp);
      end
   endtask

   task automatic cycles(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask

   task automatic wr_reg(input logic [7:0] addr, input logic [7:0] data);
      @(posedge core_clk);
      sfr_addr  <= addr;
      sfr_wdata <= data;
      sfr_wr    <= 1'b1;
      @(posedge core_clk);
      sfr_wr    <= 1'b0;
      #1;
   endtask

   task automatic rd_chk(input logic [7:0] addr, input logic [7:0] exp);
      @(posedge core_clk);
      sfr_addr <= addr;
      sfr_rd   <= 1'b1;
      @(posedge core_clk);
      sfr_rd   <= 1'b0;
      #1;
      chk8(sfr_rdata, exp, "register read");
   endtask

   task automatic wait_switch(output int n);
      n = 0;
      while (analog_write_block !== 1'b0 && n < 5000)
      begin
         @(posedge core_clk);
         #1;
         n++;
      end
      if (n >= 5000)
      begin
         err_count++;
         $display("CHECK FAILED at %0t: clock switch never finished", $time);
         final_report();
      end
   endtask

   task automatic wake();
      @(posedge core_clk);
      wakeup_event <= 1'b1;
      cycles(5);
      @(posedge core_clk);
      wakeup_event <= 1'b0;
      cycles(2);
   endtask

   task automatic test_reset_values();
      rd_chk(8'h80, csc_pkg::CTRL_RESET);
      chk1(cpu_clock_run, 1'b1, "cpu run");
      chk1(metering_clock_run, 1'b1, "meter run");
      chk1(display_clock_run, 1'b1, "disp run");
      chk1(cpu_clock_pll, 1'b0, "cpu src");
      chk1(sleep_active, 1'b0, "sleep");
   endtask

   task automatic test_meter_gates();
      wr_reg(8'h80, 8'h80);
      chk1(metering_clock_pll, 1'b1, "meter src");
      rd_chk(8'h80, 8'h80);
      wr_reg(8'h80, 8'h98);
      chk1(metering_clock_run, 1'b0, "meter gated");
      chk1(display_clock_run, 1'b1, "disp not gated");
      wr_reg(8'h80, 8'h99);
      chk1(cpu_clock_pll, 1'b1, "cpu src pll");
      chk1(display_clock_run, 1'b0, "disp gated");
      pll_running <= 1'b0;
      cycles(5);
      chk1(pll_slow_fallback, 1'b1, "slow fallback");
      rd_chk(8'h80, 8'h99);
      pll_running <= 1'b1;
      cycles(5);
      wr_reg(8'h80, 8'h00);
      chk1(analog_write_block, 1'b1, "analog block");
      rd_chk(8'h80, 8'h81);
      wait_switch(n_sw);
      chk1(n_sw > csc_pkg::SWITCH_CYCLES - 6 && n_sw < csc_pkg::SWITCH_CYCLES + 2, 1'b1,
           "switch length");
      rd_chk(8'h80, 8'h00);
      chk1(display_clock_run, 1'b1, "disp runs");
   endtask

   task automatic test_quick_enable();
      wr_reg(8'h80, 8'h40);
      chk1(cpu_clock_pll, 1'b1, "quick cpu src");
      chk1(pll_quick_on, 1'b1, "quick on");
      rd_chk(8'h80, 8'h41);
      wr_reg(8'h80, 8'hc0);
      chk1(metering_clock_pll, 1'b0, "locked meter src");
      wr_reg(8'h80, 8'h00);
      chk1(pll_quick_on, 1'b0, "unlocked");
      chk1(cpu_clock_pll, 1'b1, "source kept");
      rd_chk(8'h80, 8'h01);
      wr_reg(8'h80, 8'h41);
      wr_reg(8'h80, 8'hc0);
      chk1(analog_write_block, 1'b0, "locked cpu select ignored");
      chk1(cpu_clock_pll, 1'b1, "locked cpu src");
      wr_reg(8'h80, 8'h00);
      chk1(cpu_clock_pll, 1'b1, "release keeps pll");
      wr_reg(8'h80, 8'h00);
      wait_switch(n_sw);
      chk1(cpu_clock_pll, 1'b0, "back to osc");
   endtask

   task automatic test_fallback();
      wr_reg(8'h80, 8'h30);
      chk1(cpu_clock_run, 1'b0, "cpu stopped");
      chk1(pll_force_off, 1'b1, "pll off");
      chk1(cpu_clock_pll, 1'b0, "cpu on osc");
      chk1(sleep_active, 1'b0, "no forced sleep");
      wr_reg(8'h80, 8'h70);
      chk1(pll_quick_on, 1'b0, "quick ignored");
      wake();
      chk1(cpu_clock_run, 1'b1, "resumed");
      rd_chk(8'h80, 8'h10);
      chk1(metering_clock_run, 1'b0, "gate kept");
      power_good_status <= 1'b0;
      cycles(5);
      wr_reg(8'h80, 8'h20);
      chk1(sleep_active, 1'b1, "sleep");
      chk1(deep_sleep_active, 1'b0, "not deep");
      wake();
      rd_chk(8'h80, 8'h00);
      chk1(sleep_active, 1'b0, "awake");
   endtask

   task automatic test_sleep_codes();
      logic [1:0] codes [3];
      codes = '{2'h1, 2'h3, csc_pkg::SLEEP_CODE_DEEP};
      foreach (codes[i])
      begin
         wr_reg(8'h80, {3'h0, 1'b1, 1'b0, codes[i], 1'b0});
         chk1(sleep_active, codes[i] != 2'h2, "sleep state");
         chk1(deep_sleep_active, codes[i] == 2'h2, "deep state");
         chk1(cpu_clock_run, 1'b0, "cpu stopped");
         chk1(auxiliary_clock_run, 1'b0, "aux stopped");
         wake();
         chk1(cpu_clock_run, 1'b1, "cpu resumed");
         rd_chk(8'h80, 8'h10);
      end
      wr_reg(8'h80, 8'h00);
   endtask

   task automatic test_unmapped();
      wr_reg(8'h81, 8'hff);
      rd_chk(8'h80, 8'h00);
      rd_chk(8'h81, 8'h00);
      chk1(cpu_clock_run, 1'b1, "unmapped write ignored");
   endtask

   initial
   begin
      repeat (8) @(posedge core_clk);
      srst <= 1'b0;
      cycles(3);
      test_reset_values();
      test_meter_gates();
      test_quick_enable();
      test_fallback();
      test_sleep_codes();
      test_unmapped();
      final_report();
   end
endmodule // tb_top
